/* rtl/bod_boot_map.vh */
`ifndef BOD_BOOT_MAP_VH
`define BOD_BOOT_MAP_VH

// Program memory window of the internal flash.
`define BOD_PM_LO          16'h0000
`define BOD_PM_HI          16'h47FF
// Interrupt vector region at the bottom of program space.
`define BOD_VEC_AREA_HI    16'h00FF
// Option-byte cells; only the upper two carry meaning.
`define BOD_OPT_LO         16'h003C
`define BOD_OPT_HI         16'h003F
`define BOD_OPT_CFG        16'h003E
`define BOD_OPT_WAKE       16'h003F
// Value of an erased option byte.
`define BOD_OPT_ERASED     8'hFF
// Reset vectors, normal and relocated.
`define BOD_VEC_NORMAL     16'h0100
`define BOD_VEC_RELOC0     16'h0200
`define BOD_VEC_RELOC1     16'h0300
`define BOD_VEC_RELOC2     16'h0500
`define BOD_VEC_RELOC3     16'h0900
// Bit positions inside the configuration byte.
`define BOD_CFG_RELOC_N    7
`define BOD_CFG_VSEL_HI    6
`define BOD_CFG_VSEL_LO    5
`define BOD_CFG_PROT_N     2
`define BOD_CFG_PSIZE_HI   1
`define BOD_CFG_PSIZE_LO   0
// Bit position inside the wake byte.
`define BOD_WAKE_RST_N     0
// Register file: address and data width and mapped register counts.
`define BOD_RF_WIDTH       8
`define BOD_RF_TOTAL       333
`define BOD_RF_GP          272
`define BOD_RF_CTL         22
`define BOD_RF_PER         39
// Register file address boundaries.
`define BOD_RF_SET_LO      8'hC0
`define BOD_RF_CTL_LO      8'hD0
`define BOD_RF_PER_LO      8'hE0
// Register class codes.
`define BOD_RF_CLS_GP      2'h0
`define BOD_RF_CLS_CTL     2'h1
`define BOD_RF_CLS_PER     2'h2
`define BOD_RF_CLS_NONE    2'h3

`endif

/* rtl/bod_boot_option_decoder.v */
`timescale 1ns/1ps
`include "bod_boot_map.vh"

module bod_boot_option_decoder #(
   parameter PM_AW = 16,             // Program memory address width.
   parameter PORT_W = 8              // Width of the wake port.
) (
   input  wire              i_sys_clk,      // System clock, 40 MHz.
   input  wire              i_reset_n,      // Synchronous reset, low.
   input  wire [7:0]        i_pm_data,      // Flash read data.
   input  wire [PM_AW-1:0]  i_cpu_addr,     // Core fetch address.
   input  wire              i_cpu_rd,       // Core fetch strobe.
   input  wire              i_fl_req,       // Erase or program request.
   input  wire [PM_AW-1:0]  i_fl_addr,      // Target of that request.
   input  wire              i_stop_mode,    // Core is in stop mode.
   input  wire [PORT_W-1:0] i_wake_port,    // First wake port pins.
   input  wire [PORT_W-1:0] i_ext_int_en,   // Per-pin interrupt enable.
   input  wire [7:0]        i_rf_addr,      // Register file address.
   input  wire              i_rf_rd,        // Register file access.
   input  wire              i_rf_set2,      // Indirect or indexed mode.
   input  wire              i_rf_bank1,     // Upper bank selected.
   output reg  [PM_AW-1:0]  o_pm_addr,      // Flash read address.
   output reg               o_pm_rd,        // Flash read strobe.
   output reg               o_cpu_hold,     // Core held while loading.
   output reg               o_boot_go,      // One pulse: start fetching.
   output reg  [PM_AW-1:0]  o_reset_vector, // First fetch address.
   output reg               o_bl_area_en,   // Boot-loader area in use.
   output reg  [PM_AW-1:0]  o_bl_area_end,  // Last byte of that area.
   output reg               o_prot_en,      // Write protection active.
   output reg  [PM_AW-1:0]  o_prot_end,     // Last protected byte.
   output reg               o_fetch_err,    // Fetch outside the flash.
   output reg               o_opt_cell_rd,  // Fetch hit an option cell.
   output reg               o_fl_grant,     // Erase/program allowed.
   output reg               o_fl_deny,      // Erase/program refused.
   output reg               o_stop_release, // One pulse: leave stop.
   output reg               o_wake_reset,   // One pulse: system reset.
   output reg  [1:0]        o_rf_class,     // Class of register hit.
   output reg               o_rf_valid      // Class output is fresh.
);

   // One-hot loader states.
   localparam [4:0] S_ADDR_CFG  = 5'h01;   // Cell 3Eh on the address bus.
   localparam [4:0] S_ADDR_WAKE = 5'h02;   // Cell 3Fh out, 3Eh returns.
   localparam [4:0] S_GET_WAKE  = 5'h04;   // Cell 3Fh returns.
   localparam [4:0] S_DECODE    = 5'h08;   // Decoded values latched.
   localparam [4:0] S_RUN       = 5'h10;   // Normal operation.

   reg [4:0]        state_q;       // Loader state.
   reg [4:0]        state_d;       // Next loader state.
   reg [7:0]        opt_cfg_q;     // Captured configuration byte.
   reg [7:0]        opt_wake_q;    // Captured wake byte.
   reg [PORT_W-1:0] port_q;        // Previous wake-port sample.
   reg [PM_AW-1:0]  vec_d;         // Decoded vector.
   reg [PM_AW-1:0]  psize_end_d;   // Decoded protection end.
   reg              wake_rst_q;    // Reset-on-wake option, held.

   wire             cpu_in_pm;     // Fetch address inside flash.
   wire             cpu_in_opt;    // Fetch address on an option cell.
   wire             fl_in_pm;      // Write target inside flash.
   wire             fl_in_prot;    // Write target inside protection.
   wire [PORT_W-1:0] fall;         // Falling edges this cycle.
   wire [PORT_W-1:0] wake_mask;    // Pins allowed to wake.

   // Flash window for fetches.
   bod_range_chk #(.W(PM_AW)) u_cpu_pm (
      .i_addr (i_cpu_addr),
      .i_lo   (`BOD_PM_LO),
      .i_hi   (`BOD_PM_HI),
      .o_hit  (cpu_in_pm)
   );

   // Option cells inside the vector region are not program code.
   bod_range_chk #(.W(PM_AW)) u_cpu_opt (
      .i_addr (i_cpu_addr),
      .i_lo   (`BOD_OPT_LO),
      .i_hi   (`BOD_OPT_HI),
      .o_hit  (cpu_in_opt)
   );

   // Flash window for erase and program targets.
   bod_range_chk #(.W(PM_AW)) u_fl_pm (
      .i_addr (i_fl_addr),
      .i_lo   (`BOD_PM_LO),
      .i_hi   (`BOD_PM_HI),
      .o_hit  (fl_in_pm)
   );

   // Protected boot-loader region starts at the normal vector.
   bod_range_chk #(.W(PM_AW)) u_fl_prot (
      .i_addr (i_fl_addr),
      .i_lo   (`BOD_VEC_NORMAL),
      .i_hi   (o_prot_end),
      .o_hit  (fl_in_prot)
   );

   // Pins are synchronous, so one previous sample finds the edge.
   assign fall = port_q & ~i_wake_port;

   // With reset-on-wake every port pin counts, else only enabled ones.
   assign wake_mask = wake_rst_q ? {PORT_W{1'b1}} : i_ext_int_en;

   // Decode the vector and protection size from the captured byte.
   always @* begin
      vec_d       = `BOD_VEC_NORMAL;
      psize_end_d = `BOD_VEC_NORMAL;
      // A set relocation bit leaves the select bits meaningless.
      if (!opt_cfg_q[`BOD_CFG_RELOC_N]) begin
         case (opt_cfg_q[`BOD_CFG_VSEL_HI:`BOD_CFG_VSEL_LO])
            2'h0: vec_d = `BOD_VEC_RELOC0;
            2'h1: vec_d = `BOD_VEC_RELOC1;
            2'h2: vec_d = `BOD_VEC_RELOC2;
            default: vec_d = `BOD_VEC_RELOC3;
         endcase
      end
      // Protection sizes follow the same four steps as the vectors.
      case (opt_cfg_q[`BOD_CFG_PSIZE_HI:`BOD_CFG_PSIZE_LO])
         2'h0: psize_end_d = `BOD_VEC_RELOC0 - 16'h0001;
         2'h1: psize_end_d = `BOD_VEC_RELOC1 - 16'h0001;
         2'h2: psize_end_d = `BOD_VEC_RELOC2 - 16'h0001;
         default: psize_end_d = `BOD_VEC_RELOC3 - 16'h0001;
      endcase
   end

   // Loader sequence: two cell reads, one decode step, then run.
   always @* begin
      case (state_q)
         S_ADDR_CFG:  state_d = S_ADDR_WAKE;
         S_ADDR_WAKE: state_d = S_GET_WAKE;
         S_GET_WAKE:  state_d = S_DECODE;
         S_DECODE:    state_d = S_RUN;
         S_RUN:       state_d = S_RUN;   // Held until the next reset.
         default:     state_d = S_ADDR_CFG;
      endcase
   end

   // State register; reset restarts the option read.
   always @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         state_q <= S_ADDR_CFG;
      end else begin
         state_q <= state_d;
      end
   end

   // Option capture. Cells 3Ch and 3Dh are never read by the loader.
   always @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         opt_cfg_q  <= `BOD_OPT_ERASED;
         opt_wake_q <= `BOD_OPT_ERASED;
         wake_rst_q <= 1'b0;
      end else begin
         if (state_q == S_ADDR_WAKE) begin
            opt_cfg_q <= i_pm_data;
         end
         if (state_q == S_GET_WAKE) begin
            opt_wake_q <= i_pm_data;
         end
         // Held copy is taken once and cannot change before reset.
         if (state_q == S_DECODE) begin
            wake_rst_q <= ~opt_wake_q[`BOD_WAKE_RST_N];
         end
      end
   end

   // Decoded settings latch once and stay put while running.
   always @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_reset_vector <= `BOD_VEC_NORMAL;
         o_bl_area_en   <= 1'b0;
         o_bl_area_end  <= `BOD_VEC_NORMAL;
         o_prot_en      <= 1'b0;
         o_prot_end     <= `BOD_VEC_NORMAL;
      end else if (state_q == S_DECODE) begin
         o_reset_vector <= vec_d;
         o_bl_area_en   <= ~opt_cfg_q[`BOD_CFG_RELOC_N];
         o_bl_area_end  <= vec_d - 16'h0001;
         o_prot_en      <= ~opt_cfg_q[`BOD_CFG_PROT_N];
         o_prot_end     <= psize_end_d;
      end
   end

   // Core hold and the start pulse; the core sits still until decode.
   always @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_cpu_hold <= 1'b1;
         o_boot_go  <= 1'b0;
      end else begin
         o_cpu_hold <= (state_d != S_RUN);
         o_boot_go  <= (state_q == S_DECODE);
      end
   end

   // Program memory port: loader reads first, then core fetches.
   // Addresses outside the flash get no read strobe, since there is
   // no external memory to answer them; the error pulse goes instead.
   always @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_pm_addr     <= `BOD_OPT_CFG;
         o_pm_rd       <= 1'b1;
         o_fetch_err   <= 1'b0;
         o_opt_cell_rd <= 1'b0;
      end else begin
         case (state_q)
            S_ADDR_CFG: begin
               o_pm_addr     <= `BOD_OPT_WAKE;
               o_pm_rd       <= 1'b1;
               o_fetch_err   <= 1'b0;
               o_opt_cell_rd <= 1'b0;
            end
            S_RUN: begin
               o_pm_addr     <= i_cpu_addr;
               o_pm_rd       <= i_cpu_rd & cpu_in_pm;
               o_fetch_err   <= i_cpu_rd & ~cpu_in_pm;
               o_opt_cell_rd <= i_cpu_rd & cpu_in_opt;
            end
            default: begin
               o_pm_rd       <= 1'b0;
               o_fetch_err   <= 1'b0;
               o_opt_cell_rd <= 1'b0;
            end
         endcase
      end
   end

   // Erase and program guard, answered one cycle after the request.
   always @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_fl_grant <= 1'b0;
         o_fl_deny  <= 1'b0;
      end else if (state_q == S_RUN && i_fl_req) begin
         // Refused outside the flash or inside an active protection.
         o_fl_deny  <= ~fl_in_pm | (o_prot_en & fl_in_prot);
         o_fl_grant <= fl_in_pm & ~(o_prot_en & fl_in_prot);
      end else begin
         o_fl_grant <= 1'b0;
         o_fl_deny  <= 1'b0;
      end
   end

   // Stop-mode wake; a reset is raised only with reset-on-wake set.
   always @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         port_q         <= {PORT_W{1'b1}};
         o_stop_release <= 1'b0;
         o_wake_reset   <= 1'b0;
      end else begin
         port_q <= i_wake_port;
         if (state_q == S_RUN && i_stop_mode && |(fall & wake_mask)) begin
            o_stop_release <= 1'b1;
            o_wake_reset   <= wake_rst_q;
         end else begin
            o_stop_release <= 1'b0;
            o_wake_reset   <= 1'b0;
         end
      end
   end

   // Register file class decode on the eight-bit register path.
   // The upper 64 addresses split by addressing mode and bank.
   always @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_rf_class <= `BOD_RF_CLS_NONE;
         o_rf_valid <= 1'b0;
      end else begin
         o_rf_valid <= i_rf_rd;
         if (!i_rf_rd) begin
            o_rf_class <= `BOD_RF_CLS_NONE;
         end else if (i_rf_addr < `BOD_RF_SET_LO || i_rf_set2) begin
            o_rf_class <= `BOD_RF_CLS_GP;
         end else if (i_rf_addr < `BOD_RF_CTL_LO) begin
            o_rf_class <= `BOD_RF_CLS_GP;
         end else if (i_rf_addr < `BOD_RF_PER_LO && !i_rf_bank1) begin
            o_rf_class <= `BOD_RF_CLS_CTL;
         end else if (i_rf_addr >= `BOD_RF_PER_LO) begin
            o_rf_class <= `BOD_RF_CLS_PER;
         end else begin
            o_rf_class <= `BOD_RF_CLS_NONE;
         end
      end
   end

endmodule // bod_boot_option_decoder

/* rtl/bod_range_chk.v */
`timescale 1ns/1ps

// Inclusive address window compare; used for the flash, option-cell and protection window decodes.
module bod_range_chk #(
   parameter W = 16                  // Address width.
) (
   input  wire [W-1:0] i_addr,       // Address under test.
   input  wire [W-1:0] i_lo,         // Lowest address inside the window.
   input  wire [W-1:0] i_hi,         // Highest address inside the window.
   output wire         o_hit         // High when the address is inside.
);

   // Both bounds are inclusive, so a one-byte window has lo equal to hi.
   assign o_hit = (i_addr >= i_lo) && (i_addr <= i_hi);

endmodule // bod_range_chk

/* test/bod_checker_props.sv */
`timescale 1ns/1ps

// Port checker for the option decoder; silent while reset is low.
module bod_checker (
   input wire        i_sys_clk,
   input wire        i_reset_n,
   input wire [15:0] i_cpu_addr,
   input wire        i_cpu_rd,
   input wire        i_fl_req,
   input wire [15:0] i_fl_addr,
   input wire        i_stop_mode,
   input wire        o_pm_rd,
   input wire        o_cpu_hold,
   input wire [15:0] o_reset_vector,
   input wire        o_bl_area_en,
   input wire [15:0] o_bl_area_end,
   input wire        o_prot_en,
   input wire [15:0] o_prot_end,
   input wire        o_fetch_err,
   input wire        o_opt_cell_rd,
   input wire        o_fl_grant,
   input wire        o_fl_deny,
   input wire        o_stop_release,
   input wire        o_wake_reset
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   // Requests only count once loading is over, so gate them with hold.
   wire run_rd  = i_cpu_rd && !o_cpu_hold;
   wire run_fl  = i_fl_req && !o_cpu_hold;
   wire opt_hit = (i_cpu_addr >= 16'h003C) && (i_cpu_addr <= 16'h003F);

   property p_fetch_err; run_rd && i_cpu_addr > 16'h47FF
      |=> o_fetch_err && !o_pm_rd; endproperty
   a_fetch_err: assert property (p_fetch_err)
      else $error("no fetch err");
   property p_fetch_ok; run_rd && i_cpu_addr <= 16'h47FF
      |=> o_pm_rd && !o_fetch_err; endproperty
   a_fetch_ok: assert property (p_fetch_ok)
      else $error("fetch lost");
   property p_opt; run_rd |=> o_opt_cell_rd == $past(opt_hit); endproperty
   a_opt: assert property (p_opt)
      else $error("option cell flag");
   property p_fl_out; run_fl && i_fl_addr > 16'h47FF
      |=> o_fl_deny && !o_fl_grant; endproperty
   a_fl_out: assert property (p_fl_out)
      else $error("write beyond flash");
   property p_prot; run_fl && o_prot_en && i_fl_addr >= 16'h0100
      && i_fl_addr <= o_prot_end |=> o_fl_deny && !o_fl_grant; endproperty
   a_prot: assert property (p_prot)
      else $error("protected write");
   property p_unprot; run_fl && !o_prot_en && i_fl_addr <= 16'h47FF
      |=> o_fl_grant && !o_fl_deny; endproperty
   a_unprot: assert property (p_unprot)
      else $error("write refused");
   property p_area; o_bl_area_en
      |-> o_bl_area_end == o_reset_vector - 16'h0001; endproperty
   a_area: assert property (p_area)
      else $error("area end");
   property p_vec; !o_bl_area_en |-> o_reset_vector == 16'h0100; endproperty
   a_vec: assert property (p_vec)
      else $error("normal vector");
   // A mid-run change of the option bytes must not leak through.
   property p_held; !o_cpu_hold && !$past(o_cpu_hold)
      |-> $stable(o_reset_vector) && $stable(o_prot_end); endproperty
   a_held: assert property (p_held)
      else $error("settings moved");
   property p_wake; o_wake_reset |-> o_stop_release; endproperty
   a_wake: assert property (p_wake)
      else $error("reset without wake");
   // A release only answers a wake seen while stopped and running.
   property p_wake_stop; o_stop_release
      |-> $past(i_stop_mode) && !$past(o_cpu_hold); endproperty
   a_wake_stop: assert property (p_wake_stop)
      else $error("release outside stop");
endmodule // bod_checker

bind bod_boot_option_decoder bod_checker u_chk (
   .i_sys_clk, .i_reset_n, .i_cpu_addr, .i_cpu_rd, .i_fl_req, .i_fl_addr,
   .i_stop_mode,
   .o_pm_rd, .o_cpu_hold, .o_reset_vector, .o_bl_area_en, .o_bl_area_end,
   .o_prot_en, .o_prot_end, .o_fetch_err, .o_opt_cell_rd, .o_fl_grant,
   .o_fl_deny, .o_stop_release, .o_wake_reset);

/* test/bod_flash_model.sv */
`timescale 1ns/1ps

// Program flash seen from the decoder: one cycle read latency.
module bod_flash_model (
   input  wire        i_sys_clk,
   input  wire [15:0] i_pm_addr,
   input  wire        i_pm_rd,
   input  wire [7:0]  i_opt_cfg,
   input  wire [7:0]  i_opt_wake,
   output wire [7:0]  o_pm_data
);
   logic [7:0] data_q = 8'h5A;  // Read data register.
   assign o_pm_data = data_q;
   // Without a strobe the byte toggles, so a stale value is never reused.
   always @(posedge i_sys_clk) begin
      if (i_pm_rd) begin
         case (i_pm_addr)
            16'h003E: data_q <= i_opt_cfg;
            16'h003F: data_q <= i_opt_wake;
            default:  data_q <= i_pm_addr[7:0] ^ i_pm_addr[15:8];
         endcase
      end else begin
         data_q <= ~data_q;
      end
   end
endmodule // bod_flash_model

/* test/tb_top.sv */
`timescale 1ns/1ps

`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
   err_count++; $display("ERROR %s exp=%0h got=%0h", nm, ex, got); end end

// Self-checking bench; inputs change on the falling edge.
module tb_top;
   logic        clk = 1'b0, rst_n = 1'b0, cpu_rd = 1'b0, fl_req = 1'b0;
   logic        stop = 1'b0, rf_rd = 1'b0, set2 = 1'b0, bank1 = 1'b0;
   logic [7:0]  opt_cfg = 8'hFF, opt_wake = 8'hFF, port = 8'hFF;
   logic [7:0]  int_en = 8'h00, rf_addr = 8'h00;
   logic [15:0] cpu_addr = 16'h0000, fl_addr = 16'h0000;
   wire  [7:0]  pm_data;
   wire  [15:0] pm_addr, vec, a_end, p_end;
   wire  [1:0]  rf_cls;
   wire         pm_rd, hold, go, a_en, p_en, f_err, opt_rd, grant, deny;
   wire         rel, wrst, rf_v;
   int          err_count = 0, num_checks = 0;

   always #12.5 clk = ~clk;

   bod_boot_option_decoder u_dut (
      .i_sys_clk(clk), .i_reset_n(rst_n), .i_pm_data(pm_data),
      .i_cpu_addr(cpu_addr), .i_cpu_rd(cpu_rd), .i_fl_req(fl_req),
      .i_fl_addr(fl_addr), .i_stop_mode(stop), .i_wake_port(port),
      .i_ext_int_en(int_en), .i_rf_addr(rf_addr), .i_rf_rd(rf_rd),
      .i_rf_set2(set2), .i_rf_bank1(bank1), .o_pm_addr(pm_addr),
      .o_pm_rd(pm_rd), .o_cpu_hold(hold), .o_boot_go(go),
      .o_reset_vector(vec), .o_bl_area_en(a_en), .o_bl_area_end(a_end),
      .o_prot_en(p_en), .o_prot_end(p_end), .o_fetch_err(f_err),
      .o_opt_cell_rd(opt_rd), .o_fl_grant(grant), .o_fl_deny(deny),
      .o_stop_release(rel), .o_wake_reset(wrst), .o_rf_class(rf_cls),
      .o_rf_valid(rf_v));

   bod_flash_model u_flash (
      .i_sys_clk(clk), .i_pm_addr(pm_addr), .i_pm_rd(pm_rd),
      .i_opt_cfg(opt_cfg), .i_opt_wake(opt_wake), .o_pm_data(pm_data));

   // Prints the counts and the verdict, then stops the run.
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Resets with the given option bytes; loading takes four edges.
   task automatic boot(input logic [7:0] cfg, input logic [7:0] wk);
      opt_cfg = cfg;
      opt_wake = wk;
      rst_n = 1'b0;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      `CHK("boot_go", 1'b1, go)
      `CHK("cpu_hold", 1'b0, hold)
   endtask

   // Every vector code and protection size, plus the erased value.
   task automatic t_options;
      logic [7:0]  cf [6] = '{8'hFF, 8'h1B, 8'h3A, 8'h59, 8'h7C, 8'hE0};
      logic [15:0] ev, pe;
      for (int i = 0; i < 6; i++) begin
         boot(cf[i], 8'hFF);
         ev = cf[i][7] ? 16'h0100 : 16'h0100 + (16'h0100 << cf[i][6:5]);
         pe = (16'h0100 << cf[i][1:0]) + 16'h00FF;
         `CHK("vector", ev, vec)
         `CHK("area_en", ~cf[i][7], a_en)
         if (!cf[i][7]) `CHK("area_end", ev - 16'h0001, a_end)
         `CHK("prot_en", ~cf[i][2], p_en)
         if (!cf[i][2]) `CHK("prot_end", pe, p_end)
         opt_cfg = ~cf[i];
         repeat (3) @(negedge clk);
         `CHK("vec_held", ev, vec)
      end
      $display("test options done");
   endtask

   // Back-to-back fetches across the flash edge and the option cells.
   task automatic t_fetch;
      logic [15:0] fa [8] = '{16'h0000, 16'h003C, 16'h003D, 16'h003F,
                              16'h0100, 16'h47FF, 16'h4800, 16'hFFFF};
      logic        oc;
      for (int i = 0; i < 8; i++) begin
         cpu_rd = 1'b1;
         cpu_addr = fa[i];
         @(negedge clk);
         `CHK("fetch_err", fa[i] > 16'h47FF, f_err)
         `CHK("pm_rd", fa[i] <= 16'h47FF, pm_rd)
         oc = fa[i] >= 16'h003C && fa[i] <= 16'h003F;
         `CHK("opt_cell", oc, opt_rd)
         if (fa[i] <= 16'h47FF) `CHK("pm_addr", fa[i], pm_addr)
      end
      cpu_rd = 1'b0;
      $display("test fetch done");
   endtask

   // Erase or program requests around the protected region edges.
   task automatic t_guard(input logic [7:0] cfg);
      logic [15:0] ga [6] = '{16'h00FF, 16'h0100, 16'h02FF, 16'h0300,
                              16'h47FF, 16'h4800};
      logic        dn;
      boot(cfg, 8'hFF);
      for (int i = 0; i < 6; i++) begin
         fl_req = 1'b1;
         fl_addr = ga[i];
         @(negedge clk);
         dn = ga[i] > 16'h47FF || (!cfg[2] && ga[i] >= 16'h0100
              && ga[i] <= (16'h0100 << cfg[1:0]) + 16'h00FF);
         `CHK("fl_deny", dn, deny)
         `CHK("fl_grant", !dn, grant)
      end
      fl_req = 1'b0;
      $display("test guard done");
   endtask

   // One pin falls while stopped; the answer lasts a single cycle.
   task automatic t_wake(input logic [7:0] wk, input logic [7:0] en,
                         input logic [7:0] fall, input logic rl);
      boot(8'hFF, wk);
      stop = 1'b1;
      int_en = en;
      @(negedge clk);
      port = ~fall;
      @(negedge clk);
      `CHK("stop_release", rl, rel)
      `CHK("wake_reset", rl && !wk[0], wrst)
      port = 8'hFF;
      stop = 1'b0;
      @(negedge clk);
      `CHK("release_end", 1'b0, rel)
      $display("test wake done");
   endtask

   // Register classes by address, set and bank.
   task automatic t_regs;
      logic [11:0] rt [7] = '{12'h000, 12'hC50, 12'hD51, 12'hD57,
                              12'hD58, 12'hE02, 12'hFF6};
      for (int i = 0; i < 7; i++) begin
         rf_rd = 1'b1;
         {rf_addr, set2, bank1} = rt[i][11:2];
         @(negedge clk);
         `CHK("rf_class", rt[i][1:0], rf_cls)
         `CHK("rf_valid", 1'b1, rf_v)
      end
      rf_rd = 1'b0;
      $display("test regs done");
   endtask

   initial begin
      t_options();
      t_fetch();
      t_guard(8'hF9);
      t_guard(8'hFD);
      t_wake(8'hFE, 8'h00, 8'h08, 1'b1);
      t_wake(8'hFF, 8'h01, 8'h01, 1'b1);
      t_wake(8'hFF, 8'h01, 8'h08, 1'b0);
      t_regs();
      summarize();
   end

   // Cuts a hang short well past the expected run length.
   initial begin
      repeat (5000) @(posedge clk);
      err_count++;
      summarize();
   end
endmodule // tb_top
